// ==== hw/twu_pkg.sv ====
/*
 * Constants for the two-wire unit: register map, control and status
 * fields, status codes and bit timing.
 * Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
// Functional notes
// - Wired-AND clock: shortest high phase and longest low phase win.
// - High and low counters restart on every observed clock line edge.
// - Sample data line after each driven bit; mismatch means arbitration lost.
// - Loss only when we released data high and the line reads low.
// - On loss switch to slave mode and compare the winner's address.
// - After loss release data; clock only until current packet ends.
// - Arbitration checks continue through data packets, bit by bit.
// - Flag set after every bus event except a stop; interrupt needs local and global enable.
// - Status register holds a bus state code whenever the flag is set.
// - Writing one to the flag bit clears it; zero leaves it.
// - No operation while flag set; run the control operation once cleared.
// - After a sent start, set flag and load start-sent status.
// - After a sent packet, set flag with status telling acknowledge or not.
// - One data register holds address-with-direction or data byte.
// - A completed stop does not set the flag.
// - Clock line held low while the flag is set, except after arbitration loss, when it is released at packet end.
// - Arbitration loss also sets the flag.
// - Address packet: seven address bits first, then direction, then ack.
package twu_pkg;
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_STATUS  = 8'h04;
   localparam logic [7:0] OFF_DATA    = 8'h08;
   localparam logic [7:0] OFF_OWNADDR = 8'h0C;

   localparam int CTL_FLAG  = 7;
   localparam int CTL_ACK   = 6;
   localparam int CTL_START = 5;
   localparam int CTL_STOP  = 4;
   localparam int CTL_EN    = 2;
   localparam int CTL_IE    = 0;

   localparam logic [7:0] ST_START     = 8'h08;
   localparam logic [7:0] ST_RSTART    = 8'h10;
   localparam logic [7:0] ST_AW_ACK    = 8'h18;
   localparam logic [7:0] ST_AW_NACK   = 8'h20;
   localparam logic [7:0] ST_DT_ACK    = 8'h28;
   localparam logic [7:0] ST_DT_NACK   = 8'h30;
   localparam logic [7:0] ST_ARB_LOST  = 8'h38;
   localparam logic [7:0] ST_AR_ACK    = 8'h40;
   localparam logic [7:0] ST_AR_NACK   = 8'h48;
   localparam logic [7:0] ST_DR_ACK    = 8'h50;
   localparam logic [7:0] ST_DR_NACK   = 8'h58;
   localparam logic [7:0] ST_LOST_ADDR = 8'h68;
   localparam logic [7:0] ST_IDLE      = 8'hF8;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   localparam int CLK_HZ       = 40_000_000;
   localparam int HALF_NS      = 2_500;
   localparam int HALF_CYC     = (HALF_NS * (CLK_HZ / 1_000_000)) / 1_000;
   localparam int PACKET_BITS  = 9;
endpackage : twu_pkg

// ==== hw/twu_top.sv ====
/*
 * Two-wire unit: byte-oriented multi-master controller with AXI4-Lite
 * registers, clock synchronisation, arbitration and a completion flag.
 * Assumes open-drain bus lines resolved outside; pins are asynchronous.
 */
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module twu_top #(
   parameter int HALF = twu_pkg::HALF_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cpu_global_ie,
   output logic             irq,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   initial begin
      if (HALF < 2 || HALF > 65535)
         $error("HALF out of range");
   end

   typedef enum logic [2:0] {
      TWU_IDLE  = 3'b000,
      TWU_START = 3'b001,
      TWU_BITS  = 3'b010,
      TWU_STOP  = 3'b011,
      TWU_WAIT  = 3'b100,
      TWU_SLV   = 3'b101
   } twu_state_t;

   twu_state_t  state;
   logic [1:0]  scl_sy, sda_sy;
   logic        scl_q, sda_q;
   logic [7:0]  control_reg, bus_status_reg, byte_shift_reg, own_addr;
   logic        flag;
   logic [15:0] tcnt;
   logic [3:0]  bitn;
   logic [1:0]  ph;
   logic        lost, is_addr, rd_dir, drive_low, started, acked;
   logic        aw_hold, w_hold;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic        wr_fire;

   wire scl_s    = scl_sy[1];
   wire sda_s    = sda_sy[1];
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire tdone    = (tcnt == 16'(HALF - 1));

   // Bus pins are asynchronous; two stages before any use.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_sy <= 2'b11;
         sda_sy <= 2'b11;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[0], scl_i};
         sda_sy <= {sda_sy[0], sda_i};
         scl_q  <= scl_s;
         sda_q  <= sda_s;
      end
   end

   // AXI4-Lite write: address and data accepted in either order.
   assign wr_fire = aw_hold & w_hold & ~s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold       <= 1'b0;
         w_hold        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= twu_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_hold & ~s_axi_awready;
         s_axi_wready  <= ~w_hold & ~s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
               twu_pkg::OFF_CONTROL, twu_pkg::OFF_DATA,
               twu_pkg::OFF_OWNADDR, twu_pkg::OFF_STATUS:
                  s_axi_bresp <= twu_pkg::RESP_OKAY;
               default: s_axi_bresp <= twu_pkg::RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire wr_ctl  = wr_fire && aw_addr == twu_pkg::OFF_CONTROL && s_axi_wstrb[0];
   wire wr_dat  = wr_fire && aw_addr == twu_pkg::OFF_DATA && s_axi_wstrb[0];
   wire wr_own  = wr_fire && aw_addr == twu_pkg::OFF_OWNADDR && s_axi_wstrb[0];
   wire clr_req = wr_ctl && w_data[twu_pkg::CTL_FLAG];
   // The enable bit of the same control write gates the operation it asks for.
   wire enable  = w_data[twu_pkg::CTL_EN];

   // AXI4-Lite read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= twu_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= twu_pkg::RESP_OKAY;
            case (s_axi_araddr)
               twu_pkg::OFF_CONTROL:
                  s_axi_rdata <= {24'h000000, flag, control_reg[6:0]};
               twu_pkg::OFF_STATUS:
                  s_axi_rdata <= {24'h000000, bus_status_reg};
               twu_pkg::OFF_DATA:
                  s_axi_rdata <= {24'h000000, byte_shift_reg};
               twu_pkg::OFF_OWNADDR:
                  s_axi_rdata <= {24'h000000, own_addr};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= twu_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_reg <= 8'h00;
         own_addr    <= 8'h00;
      end else begin
         if (wr_ctl)
            control_reg <= {1'b0, w_data[6:0]};
         if (wr_own)
            own_addr <= w_data[7:0];
      end
   end

   // Phase timer restarts on every edge of the shared clock line, so
   // the longest low and shortest high among masters set the pace.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tcnt <= 16'h0000;
      else if (scl_rise || scl_fall || tdone || state == TWU_IDLE)
         tcnt <= 16'h0000;
      else
         tcnt <= tcnt + 16'h0001;
   end

   wire flag_set = (state == TWU_START && ph == 2'd2 && tdone)
                 || (state == TWU_BITS && bitn == 4'(twu_pkg::PACKET_BITS)
                     && scl_fall && !lost)
                 || (state == TWU_BITS && scl_rise && drive_low == 1'b0
                     && !sda_s && bitn < 4'd8 && !lost);

   // Completion flag: hardware set wins over a software clear.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         flag <= 1'b0;
      else if (flag_set)
         flag <= 1'b1;
      else if (clr_req)
         flag <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= flag & control_reg[twu_pkg::CTL_IE] & cpu_global_ie;
   end

   // Main sequencer. Phases step through start (0 to 2) and stop (0 to 1).
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state          <= TWU_IDLE;
         bitn           <= 4'h0;
         ph             <= 2'd0;
         lost           <= 1'b0;
         is_addr        <= 1'b0;
         rd_dir         <= 1'b0;
         drive_low      <= 1'b0;
         started        <= 1'b0;
         acked          <= 1'b0;
         scl_o          <= 1'b0;
         scl_oe         <= 1'b0;
         sda_o          <= 1'b0;
         sda_oe         <= 1'b0;
         byte_shift_reg <= 8'h00;
         bus_status_reg <= twu_pkg::ST_IDLE;
      end else begin
         sda_o <= 1'b0;
         scl_o <= 1'b0;
         if (wr_dat && (flag || state == TWU_IDLE))
            byte_shift_reg <= w_data[7:0];
         unique case (state)
            TWU_IDLE, TWU_WAIT: begin
               scl_oe <= flag && started;
               // Operation runs only once the flag is cleared.
               if (clr_req && enable) begin
                  if (w_data[twu_pkg::CTL_START]) begin
                     state <= TWU_START;
                     ph    <= 2'd0;
                     sda_oe <= 1'b0;
                     scl_oe <= 1'b0;
                  end else if (w_data[twu_pkg::CTL_STOP] && started) begin
                     state  <= TWU_STOP;
                     ph     <= 2'd0;
                     sda_oe <= 1'b1;
                  end else if (started) begin
                     state     <= TWU_BITS;
                     bitn      <= 4'h0;
                     lost      <= 1'b0;
                     drive_low <= ~byte_shift_reg[7];
                     sda_oe    <= ~byte_shift_reg[7];
                  end
               end
            end
            TWU_START: begin
               // Release both, then pull data low with clock high, then clock.
               if (tdone) begin
                  ph <= ph + 2'd1;
                  if (ph == 2'd1)
                     sda_oe <= 1'b1;
                  if (ph == 2'd2) begin
                     scl_oe  <= 1'b1;
                     bus_status_reg <= started ? twu_pkg::ST_RSTART
                                               : twu_pkg::ST_START;
                     started <= 1'b1;
                     is_addr <= 1'b1;
                     state   <= TWU_WAIT;
                  end
               end
            end
            TWU_BITS: begin
               if (scl_fall) begin
                  scl_oe <= 1'b1;
                  if (bitn == 4'(twu_pkg::PACKET_BITS)) begin
                     // Packet done; a loser lets go of both lines.
                     if (lost) begin
                        state   <= TWU_IDLE;
                        scl_oe  <= 1'b0;
                        started <= 1'b0;
                     end else begin
                        state <= TWU_WAIT;
                     end
                     sda_oe <= 1'b0;
                     is_addr <= 1'b0;
                  end else if (bitn == 4'd8) begin
                     drive_low <= 1'b0;
                     sda_oe    <= 1'b0;   // release for acknowledge
                  end else begin
                     drive_low <= lost ? 1'b0 : ~byte_shift_reg[7];
                     sda_oe    <= lost ? 1'b0 : ~byte_shift_reg[7];
                  end
               end else if (tdone && scl_s == 1'b0 && scl_oe) begin
                  scl_oe <= 1'b0;
               end else if (tdone && scl_s && !scl_oe) begin
                  scl_oe <= 1'b1;
               end
               if (scl_rise) begin
                  if (bitn < 4'd8) begin
                     // Shift MSB first; sampled level replaces driven one.
                     byte_shift_reg <= {byte_shift_reg[6:0], sda_s};
                     if (bitn == 4'd7 && is_addr)
                        rd_dir <= sda_s;
                     if (!drive_low && !sda_s && !lost) begin
                        // Released high but line low: lost.
                        lost <= 1'b1;
                        bus_status_reg <= is_addr ? twu_pkg::ST_LOST_ADDR
                                                  : twu_pkg::ST_ARB_LOST;
                        state <= TWU_SLV;
                     end
                  end else begin
                     acked <= ~sda_s;
                     if (!lost)
                        bus_status_reg <= is_addr ?
                           (rd_dir ? (sda_s ? twu_pkg::ST_AR_NACK
                                            : twu_pkg::ST_AR_ACK)
                                   : (sda_s ? twu_pkg::ST_AW_NACK
                                            : twu_pkg::ST_AW_ACK))
                         : (sda_s ? twu_pkg::ST_DT_NACK
                                  : twu_pkg::ST_DT_ACK);
                  end
                  bitn <= bitn + 4'd1;
               end
            end
            TWU_SLV: begin
               // Keep clocking out the packet with data released, while the
               // shift register keeps collecting the winner's address.
               sda_oe <= 1'b0;
               if (scl_rise) begin
                  if (bitn < 4'd8)
                     byte_shift_reg <= {byte_shift_reg[6:0], sda_s};
                  bitn <= bitn + 4'd1;
               end
               if (scl_fall) begin
                  if (bitn == 4'(twu_pkg::PACKET_BITS)) begin
                     state   <= TWU_IDLE;
                     scl_oe  <= 1'b0;
                     started <= 1'b0;
                     is_addr <= 1'b0;
                  end else begin
                     scl_oe <= 1'b1;
                  end
               end else if (tdone && !scl_s && scl_oe) begin
                  scl_oe <= 1'b0;
               end else if (tdone && scl_s && !scl_oe) begin
                  scl_oe <= 1'b1;
               end
               if (is_addr && bitn == 4'd7 && scl_rise
                   && byte_shift_reg[6:0] == own_addr[6:0])
                  bus_status_reg <= twu_pkg::ST_LOST_ADDR;
            end
            TWU_STOP: begin
               // Data low, release clock, then release data; no flag.
               if (tdone) begin
                  ph <= ph + 2'd1;
                  if (ph == 2'd0)
                     scl_oe <= 1'b0;
                  if (ph == 2'd1) begin
                     sda_oe  <= 1'b0;
                     started <= 1'b0;
                     bus_status_reg <= twu_pkg::ST_IDLE;
                     state   <= TWU_IDLE;
                  end
               end
            end
            default: state <= TWU_IDLE;
         endcase
      end
   end
endmodule : twu_top

// ==== test/twu_props.sv ====
/*
 * Port checker for the two-wire unit: register read answers, interrupt
 * gating, clock stretching and clock line timing.
 * Assumes one aclk domain and a bench that resolves the open-drain lines.
 */
`timescale 1ns/1ps
module twu_props (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cpu_global_ie,
   input  wire logic        irq,
   input  wire logic        scl_i,
   input  wire logic        scl_o,
   input  wire logic        scl_oe,
   input  wire logic        sda_o,
   input  wire logic        sda_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence flag_held;
      irq && $past(irq) && $past(irq, 2);
   endsequence

   irq_gate_a: assert property (irq |-> $past(cpu_global_ie))
      else $error("irq raised without global enable");
   stretch_hold_a: assert property (flag_held |-> $past(scl_oe))
      else $error("clock line released while flag set");
   scl_high_a: assert property ($rose(scl_i) |-> !scl_oe [*3])
      else $error("clock high phase cut short");
   open_drain_a: assert property (!scl_o && !sda_o)
      else $error("bus line driven high");
   rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   rd_refuse_a: assert property (rd_taken and s_axi_araddr > 8'h0C
      |=> s_axi_rresp == twu_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped early");
   reset_idle_a: assert property ($rose(aresetn) |-> !scl_oe && !sda_oe)
      else $error("bus driven after reset");
endmodule : twu_props

// ==== test/twu_peer.sv ====
/*
 * Bus peer: a slave that acknowledges its address, optional stretching,
 * and a rival master holding data low through the first address bit.
 * Assumes wired-AND lines with pull-ups resolved by the bench.
 */
`timescale 1ns/1ps
module twu_peer #(
   parameter logic [6:0] ADDR = 7'h50
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nack,
   input  wire logic       jam,
   input  wire logic       stretch,
   output logic            scl_low,
   output logic            sda_low,
   output logic [7:0]      rx,
   output logic [3:0]      cnt
);
   logic [7:0] sh;
   logic       act;
   logic       first;
   logic       sel;

   initial begin
      cnt = 4'h0;
      act = 1'h0;
      sel = 1'h0;
      scl_low = 1'h0;
   end
   always @(negedge sda) begin
      if (scl) begin
         act = 1'h1;
         first = 1'h1;
         sel = 1'h0;
         cnt = 4'h0;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         act = 1'h0;
         cnt = 4'h0;
      end
   end
   always @(negedge scl) begin
      if (act) begin
         first = (cnt == 4'h9) ? 1'h0 : first;
         cnt = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      end
   end
   always @(posedge scl) begin
      if (cnt > 4'h0 && cnt < 4'h9) begin
         sh = {sh[6:0], sda};
         if (cnt == 4'h8) begin
            rx = sh;
            sel = first ? (sh[7:1] == ADDR) : sel;
         end
      end
   end
   // A slow slave holds every low phase for at least 300 ns.
   always @(negedge scl) begin
      if (stretch && act) begin
         scl_low = 1'h1;
         #300;
         scl_low = 1'h0;
      end
   end
   assign sda_low = (jam && cnt == 4'h1)
                 || (cnt == 4'h9 && sel && !nack);
endmodule : twu_peer

// ==== test/tb_top.sv ====
/*
 * Bench for the two-wire unit: registers, start, address and data
 * packets, stretching, interrupt masking and arbitration loss.
 * Assumes twu_peer on the bus and twu_props bound to the top module.
 */
`timescale 1ns/1ps
module tb_top;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'h0;
   logic        bready = 1'h0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'h0;
   logic        rready = 1'h0;
   logic        gie = 1'h0;
   logic        nack = 1'h0;
   logic        jam = 1'h0;
   logic        stretch = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        scl_oe, sda_oe, p_scl, p_sda;
   logic [7:0]  rx;
   logic [3:0]  p_cnt;
   wire         scl = !(scl_oe === 1'h1 || p_scl === 1'h1);
   wire         sda = !(sda_oe === 1'h1 || p_sda === 1'h1);
   int          err_count = 0;
   int          total_checks = 0;

   always #12.5 aclk = ~aclk;

   twu_top #(.HALF(4)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cpu_global_ie(gie), .irq(irq),
      .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
   twu_peer #(.ADDR(7'h50)) i_peer (
      .scl(scl), .sda(sda), .nack(nack), .jam(jam), .stretch(stretch),
      .scl_low(p_scl), .sda_low(p_sda), .rx(rx), .cnt(p_cnt));

   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", w, e, g);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask : axi_rd

   // Writes control, then polls the flag and compares the status code.
   task automatic op(input logic [31:0] ctl, input logic [7:0] st);
      logic [31:0] d;
      logic [1:0]  r;
      logic        ok;
      ok = 1'h0;
      axi_wr(twu_pkg::OFF_CONTROL, ctl);
      for (int i = 0; i < 300 && !ok; i++) begin
         axi_rd(twu_pkg::OFF_CONTROL, d, r);
         ok = d[twu_pkg::CTL_FLAG];
      end
      chk("flag", 32'h1, {31'h0, ok});
      axi_rd(twu_pkg::OFF_STATUS, d, r);
      chk("status", {24'h0, st}, d);
   endtask : op

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(twu_pkg::OFF_STATUS, d, r);
      chk("idle status", {24'h0, twu_pkg::ST_IDLE}, d);
      axi_rd(8'h10, d, r);
      chk("unmapped", {30'h0, twu_pkg::RESP_SLVERR}, {30'h0, r});
      axi_wr(twu_pkg::OFF_OWNADDR, 32'h7F);
      axi_rd(twu_pkg::OFF_OWNADDR, d, r);
      chk("own address", 32'h7F, d);
   endtask : t_regs

   task automatic t_xfer(input logic nk, input logic st, input logic g);
      logic [31:0] d;
      logic [1:0]  r;
      nack <= nk;
      stretch <= st;
      gie <= g;
      op(32'hA5, twu_pkg::ST_START);
      chk("irq", {31'h0, g}, {31'h0, irq});
      chk("scl held", 32'h0, {31'h0, scl});
      axi_wr(twu_pkg::OFF_CONTROL, 32'h05);
      axi_rd(twu_pkg::OFF_STATUS, d, r);
      chk("kept", {24'h0, twu_pkg::ST_START}, d);
      axi_wr(twu_pkg::OFF_DATA, {24'h0, 7'h50, 1'h0});
      op(32'h85, nk ? twu_pkg::ST_AW_NACK : twu_pkg::ST_AW_ACK);
      chk("address byte", 32'hA0, {24'h0, rx});
      if (!nk) begin
         axi_wr(twu_pkg::OFF_DATA, 32'h3C);
         op(32'h85, twu_pkg::ST_DT_ACK);
         chk("data byte", 32'h3C, {24'h0, rx});
      end
      axi_wr(twu_pkg::OFF_CONTROL, 32'h95);
      repeat (200) @(posedge aclk);
      axi_rd(twu_pkg::OFF_CONTROL, d, r);
      chk("stop flag", 32'h0, {31'h0, d[7]});
      chk("lines free", 32'h3, {30'h0, scl, sda});
   endtask : t_xfer

   task automatic t_arb;
      int bad;
      bad = 0;
      jam <= 1'h1;
      gie <= 1'h1;
      op(32'hA4, twu_pkg::ST_START);
      axi_wr(twu_pkg::OFF_DATA, 32'hA0);
      fork
         op(32'h84, twu_pkg::ST_LOST_ADDR);
         repeat (400) begin
            @(posedge aclk);
            if (p_cnt > 4'h1 && p_cnt < 4'h9 && sda_oe) bad++;
         end
      join
      chk("data released", 32'h0, bad);
      chk("irq masked", 32'h0, {31'h0, irq});
   endtask : t_arb

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_xfer(1'h0, 1'h0, 1'h1);
      t_xfer(1'h1, 1'h1, 1'h0);
      t_xfer(1'h0, 1'h1, 1'h1);
      t_arb();
      test_done();
   end

   // The sequence needs some 2000 cycles; this allows about thirty times that.
   initial begin
      #1_500_000;
      err_count++;
      $display("FAIL watchdog expected done seen hang");
      test_done();
   end
endmodule : tb_top

bind twu_top twu_props i_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .cpu_global_ie(cpu_global_ie), .irq(irq), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
